/* File: rtl/tcr_main_config_regs.sv */
// Purpose: Main configuration register bank of the transceiver.
// Assumes: Registers are reached only through the serial configuration port.
// Notes: Only bytes 0 to 5 are held here; other addresses read as zero.
//
// What this block does
// - Decode addresses into main, interrupt, receiver, sync, transmit, oscillator, packet groups.
// - Byte 0 bits 7-5 select operating state; standby after reset.
// - Byte 0 bits 4-2 hold the band code; reset value 100.
// - Byte 0 bits 1-0 select the sub-band; reset value 00.
// - Byte 1 bits 7-6 select continuous, buffered or packet data handling.
// - Byte 1 bits 5-4 select modulation; FSK after reset, 11 reserved.
// - Byte 1 bits 3-2 select slicer threshold method; peak after reset.
// - Byte 1 bits 1-0 set IF attenuation; none after reset.
// - Byte 2 holds FSK deviation divider; reset value 3.
// - Byte 3 holds bit-rate coefficient C; reset value 7.
// - Byte 5 bits 7-6 select amplifier ramp time; 23 us after reset.
// - Byte 5 bit 5 enables receiver low power; disabled after reset.
`timescale 1ns/1ps
`default_nettype none
module tcr_main_config_regs (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  cfg_sck,
  input  wire logic                  cfg_sel_n,
  input  wire logic                  cfg_mosi,
  output logic                       cfg_miso,
  output logic                       cfg_miso_oe,
  output tcr_pkg::tcr_main_params_t  main_params,
  output tcr_pkg::tcr_group_t        access_group
);
  import tcr_pkg::*;

  tcr_main_state_t q, d;
  tcr_port_req_t   req;
  logic [7:0]      rd_data;

  function automatic tcr_group_t group_of(input tcr_addr_t a);
    if (a <= MAIN_HI) begin
      return GRP_MAIN;
    end else if (a >= IRQ_LO && a <= IRQ_HI) begin
      return GRP_IRQ;
    end else if (a >= RX_LO && a <= RX_HI) begin
      return GRP_RX;
    end else if (a >= SYNC_LO && a <= SYNC_HI) begin
      return GRP_SYNC;
    end else if (a == TX_ADDR) begin
      return GRP_TX;
    end else if (a == OSC_ADDR) begin
      return GRP_OSC;
    end else if (a >= PKT_LO && a <= PKT_HI) begin
      return GRP_PKT;
    end
    return GRP_NONE;
  endfunction

  function automatic logic [7:0] read_byte(input tcr_main_params_t r, input tcr_addr_t a);
    if (group_of(a) != GRP_MAIN) begin
      return 8'h00;
    end
    case (a)
      MODE_BAND_ADDR: return r.mode_band;
      DATA_MOD_ADDR:  return r.data_mod;
      FSK_DEV_ADDR:   return r.fsk_deviation;
      RATE_C_ADDR:    return r.rate_coeff_c;
      RATE_D_ADDR:    return r.rate_coeff_d;
      RAMP_LP_ADDR:   return {r.ramp_lp.amp_ramp_time, r.ramp_lp.rx_low_power, RSVD_RST};
      default:        return 8'h00;
    endcase
  endfunction

  tcr_serial_port u_port (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .cfg_sck   (cfg_sck),
    .cfg_sel_n (cfg_sel_n),
    .cfg_mosi  (cfg_mosi),
    .rd_data   (rd_data),
    .req       (req),
    .miso      (cfg_miso),
    .miso_oe   (cfg_miso_oe)
  );

  assign rd_data = read_byte(q.regs, req.addr);

  always_comb begin
    d = q;
    if (req.wr_valid) begin
      d.last_group = group_of(req.addr);
      if (group_of(req.addr) == GRP_MAIN) begin
        case (req.addr)
          MODE_BAND_ADDR: d.regs.mode_band = req.wr_data;
          DATA_MOD_ADDR:  d.regs.data_mod = req.wr_data;
          FSK_DEV_ADDR:   d.regs.fsk_deviation = req.wr_data;
          RATE_C_ADDR:    d.regs.rate_coeff_c = req.wr_data;
          RATE_D_ADDR:    d.regs.rate_coeff_d = req.wr_data;
          RAMP_LP_ADDR: begin
            d.regs.ramp_lp.amp_ramp_time = req.wr_data[7:6];
            d.regs.ramp_lp.rx_low_power  = req.wr_data[5];
          end
          default: d.regs = q.regs;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q.regs       <= MAIN_PARAMS_RST;
      q.last_group <= GRP_NONE;
    end else begin
      q <= d;
    end
  end

  assign main_params  = q.regs;
  assign access_group = q.last_group;

  sequence s_write(tcr_addr_t a);
    req.wr_valid && req.addr == a;
  endsequence

  property p_other_group_ignored;
    @(posedge clk_sys) disable iff (sys_rst)
      req.wr_valid && group_of(req.addr) != GRP_MAIN |=> $stable(q.regs);
  endproperty
  a_other_group_ignored: assert property (p_other_group_ignored)
    else $error("Write outside main group changed a register.");

  property p_mode_reset;
    @(posedge clk_sys) $fell(sys_rst) |-> main_params.mode_band.chip_mode == MODE_STANDBY;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("Operating state is not standby after reset.");

  property p_band_write;
    @(posedge clk_sys) disable iff (sys_rst)
      s_write(MODE_BAND_ADDR) |=> main_params.mode_band.band == $past(req.wr_data[4:2]);
  endproperty
  a_band_write: assert property (p_band_write)
    else $error("Band code did not take the written value.");

  property p_subband_reset;
    @(posedge clk_sys) $fell(sys_rst) |->
      main_params.mode_band.subband == SUBBAND_RST && main_params.mode_band.band == BAND_RST;
  endproperty
  a_subband_reset: assert property (p_subband_reset)
    else $error("Band or sub-band reset value wrong.");

  property p_data_mode_write;
    @(posedge clk_sys) disable iff (sys_rst)
      s_write(DATA_MOD_ADDR) |=> main_params.data_mod.data_mode == $past(req.wr_data[7:6]);
  endproperty
  a_data_mode_write: assert property (p_data_mode_write)
    else $error("Data handling mode did not take the written value.");

  property p_mod_reset;
    @(posedge clk_sys) $fell(sys_rst) |-> main_params.data_mod.modulation_select == MOD_FSK
      && main_params.data_mod.slicer_threshold_method == SLICER_RST;
  endproperty
  a_mod_reset: assert property (p_mod_reset)
    else $error("Modulation or slicer reset value wrong.");

  property p_atten_write;
    @(posedge clk_sys) disable iff (sys_rst)
      s_write(DATA_MOD_ADDR) |=> main_params.data_mod.if_atten == $past(req.wr_data[1:0]);
  endproperty
  a_atten_write: assert property (p_atten_write)
    else $error("IF attenuation did not take the written value.");

  property p_dev_write;
    @(posedge clk_sys) disable iff (sys_rst)
      s_write(FSK_DEV_ADDR) |=> main_params.fsk_deviation == $past(req.wr_data);
  endproperty
  a_dev_write: assert property (p_dev_write)
    else $error("Deviation divider did not take the written value.");

  property p_coeff_reset;
    @(posedge clk_sys) $fell(sys_rst) |-> main_params.rate_coeff_c == RATE_C_RST
      && main_params.fsk_deviation == FSK_DEV_RST && main_params.rate_coeff_d == RATE_D_RST;
  endproperty
  a_coeff_reset: assert property (p_coeff_reset)
    else $error("Deviation or rate coefficient reset value wrong.");

  property p_ramp_lp_write;
    @(posedge clk_sys) disable iff (sys_rst)
      s_write(RAMP_LP_ADDR) |=> main_params.ramp_lp.amp_ramp_time == $past(req.wr_data[7:6])
      && main_params.ramp_lp.rx_low_power == $past(req.wr_data[5]);
  endproperty
  a_ramp_lp_write: assert property (p_ramp_lp_write)
    else $error("Ramp time or low power bit did not take the written value.");

  property p_hold_without_write;
    @(posedge clk_sys) disable iff (sys_rst)
      !req.wr_valid ##1 !req.wr_valid |-> $stable(main_params);
  endproperty
  a_hold_without_write: assert property (p_hold_without_write)
    else $error("Register changed without a write.");

  property p_read_back;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(cfg_miso_oe) && req.addr == DATA_MOD_ADDR
      |-> cfg_miso == $past(main_params.data_mod.data_mode[1]);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("First read bit does not match the stored byte.");

  property p_mode_write;
    @(posedge clk_sys) disable iff (sys_rst)
      s_write(MODE_BAND_ADDR) |=>
      main_params.mode_band.chip_mode == $past(req.wr_data[7:5])
      && main_params.mode_band.subband == $past(req.wr_data[1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("Operating state or sub-band did not take the written value.");

  property p_modulation_write;
    @(posedge clk_sys) disable iff (sys_rst)
      s_write(DATA_MOD_ADDR) |=>
      main_params.data_mod.modulation_select == $past(req.wr_data[5:4])
      && main_params.data_mod.slicer_threshold_method == $past(req.wr_data[3:2]);
  endproperty
  a_modulation_write: assert property (p_modulation_write)
    else $error("Modulation or slicer method did not take the written value.");

  property p_rate_c_write;
    @(posedge clk_sys) disable iff (sys_rst)
      s_write(RATE_C_ADDR) |=> main_params.rate_coeff_c == $past(req.wr_data);
  endproperty
  a_rate_c_write: assert property (p_rate_c_write)
    else $error("Rate coefficient C did not take the written value.");

  property p_rate_d_write;
    @(posedge clk_sys) disable iff (sys_rst)
      s_write(RATE_D_ADDR) |=> main_params.rate_coeff_d == $past(req.wr_data);
  endproperty
  a_rate_d_write: assert property (p_rate_d_write)
    else $error("Rate coefficient D did not take the written value.");

  property p_group_main;
    @(posedge clk_sys) disable iff (sys_rst)
      req.wr_valid && req.addr <= MAIN_HI |=> access_group == GRP_MAIN;
  endproperty
  a_group_main: assert property (p_group_main)
    else $error("Write to the main group reported another group.");

  property p_group_packet;
    @(posedge clk_sys) disable iff (sys_rst)
      req.wr_valid && req.addr >= PKT_LO && req.addr <= PKT_HI |=> access_group == GRP_PKT;
  endproperty
  a_group_packet: assert property (p_group_packet)
    else $error("Write to the packet group reported another group.");

  property p_unheld_reads_zero;
    @(posedge clk_sys) disable iff (sys_rst)
      req.addr > RAMP_LP_ADDR |-> rd_data == 8'h00;
  endproperty
  a_unheld_reads_zero: assert property (p_unheld_reads_zero)
    else $error("Address outside the held bytes did not read zero.");
endmodule
`default_nettype wire

/* File: rtl/tcr_pkg.sv */
// Purpose: Shared constants and types of the transceiver main configuration bank.
// Assumes: A five-bit register address and byte-wide registers.
// Notes: Register fields are carried as packed structs.
package tcr_pkg;

  localparam int unsigned ADDR_W = 5;
  typedef logic [ADDR_W-1:0] tcr_addr_t;

  // Address bounds of the register groups.
  localparam tcr_addr_t MAIN_LO = 5'h00;
  localparam tcr_addr_t MAIN_HI = 5'h0b;
  localparam tcr_addr_t IRQ_LO  = 5'h0c;
  localparam tcr_addr_t IRQ_HI  = 5'h0f;
  localparam tcr_addr_t RX_LO   = 5'h10;
  localparam tcr_addr_t RX_HI   = 5'h15;
  localparam tcr_addr_t SYNC_LO = 5'h16;
  localparam tcr_addr_t SYNC_HI = 5'h19;
  localparam tcr_addr_t TX_ADDR = 5'h1a;
  localparam tcr_addr_t OSC_ADDR = 5'h1b;
  localparam tcr_addr_t PKT_LO  = 5'h1c;
  localparam tcr_addr_t PKT_HI  = 5'h1e;

  // Register addresses held in this bank.
  localparam tcr_addr_t MODE_BAND_ADDR = 5'h00;
  localparam tcr_addr_t DATA_MOD_ADDR  = 5'h01;
  localparam tcr_addr_t FSK_DEV_ADDR   = 5'h02;
  localparam tcr_addr_t RATE_C_ADDR    = 5'h03;
  localparam tcr_addr_t RATE_D_ADDR    = 5'h04;
  localparam tcr_addr_t RAMP_LP_ADDR   = 5'h05;

  typedef enum logic [2:0] {
    GRP_MAIN = 3'h0,
    GRP_IRQ  = 3'h1,
    GRP_RX   = 3'h3,
    GRP_SYNC = 3'h2,
    GRP_TX   = 3'h6,
    GRP_OSC  = 3'h7,
    GRP_PKT  = 3'h5,
    GRP_NONE = 3'h4
  } tcr_group_t;

  // Operating state codes.
  localparam logic [2:0] MODE_SLEEP      = 3'h0;
  localparam logic [2:0] MODE_STANDBY    = 3'h1;
  localparam logic [2:0] MODE_SYNTH_ONLY = 3'h2;
  localparam logic [2:0] MODE_RECEIVE    = 3'h3;
  localparam logic [2:0] MODE_TRANSMIT   = 3'h4;

  typedef struct packed {
    logic [2:0] chip_mode;
    logic [2:0] band;
    logic [1:0] subband;
  } tcr_mode_band_t;

  typedef struct packed {
    logic [1:0] data_mode;
    logic [1:0] modulation_select;
    logic [1:0] slicer_threshold_method;
    logic [1:0] if_atten;
  } tcr_data_mod_t;

  typedef struct packed {
    logic [1:0] amp_ramp_time;
    logic       rx_low_power;
    logic [4:0] reserved;
  } tcr_ramp_lp_t;

  typedef struct packed {
    tcr_mode_band_t mode_band;
    tcr_data_mod_t  data_mod;
    logic [7:0]     fsk_deviation;
    logic [7:0]     rate_coeff_c;
    logic [7:0]     rate_coeff_d;
    tcr_ramp_lp_t   ramp_lp;
  } tcr_main_params_t;

  // Reset values.
  localparam logic [2:0] BAND_RST     = 3'h4;
  localparam logic [1:0] SUBBAND_RST  = 2'h0;
  localparam logic [1:0] DMODE_RST    = 2'h0;
  localparam logic [1:0] MOD_FSK      = 2'h2;
  localparam logic [1:0] SLICER_RST   = 2'h1;
  localparam logic [1:0] IF_ATTEN_RST = 2'h0;
  localparam logic [7:0] FSK_DEV_RST  = 8'h03;
  localparam logic [7:0] RATE_C_RST   = 8'h07;
  localparam logic [7:0] RATE_D_RST   = 8'h0f;
  localparam logic [1:0] RAMP_RST     = 2'h3;
  localparam logic       LOWPWR_RST   = 1'b0;
  localparam logic [4:0] RSVD_RST     = 5'h00;

  localparam tcr_main_params_t MAIN_PARAMS_RST = '{
    mode_band: '{MODE_STANDBY, BAND_RST, SUBBAND_RST},
    data_mod:  '{DMODE_RST, MOD_FSK, SLICER_RST, IF_ATTEN_RST},
    fsk_deviation: FSK_DEV_RST,
    rate_coeff_c:  RATE_C_RST,
    rate_coeff_d:  RATE_D_RST,
    ramp_lp: '{RAMP_RST, LOWPWR_RST, RSVD_RST}
  };

  // Serial frame layout: start, read flag, address, stop, then one data byte.
  localparam logic [4:0] HDR_LAST   = 5'h07;
  localparam logic [4:0] HDR_BITS   = 5'h08;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int unsigned HDR_RW_BIT   = 6;
  localparam int unsigned HDR_ADDR_LSB = 1;

  typedef struct packed {
    logic       wr_valid;
    tcr_addr_t  addr;
    logic [7:0] wr_data;
  } tcr_port_req_t;

  typedef struct packed {
    logic [1:0] sck_sync;
    logic       sck_prev;
    logic [1:0] sel_n_sync;
    logic [1:0] mosi_sync;
    logic [4:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] shift_out;
    logic       hdr_read;
    tcr_port_req_t req;
    logic       miso;
    logic       miso_oe;
  } tcr_port_state_t;

  typedef struct packed {
    tcr_main_params_t regs;
    tcr_group_t       last_group;
  } tcr_main_state_t;

endpackage

/* File: rtl/tcr_serial_port.sv */
// Purpose: Serial configuration port that turns pin frames into register requests.
// Assumes: Pins are asynchronous to clk_sys and far slower than it.
// Notes: One byte per frame; extra clocks after the data byte are ignored.
`timescale 1ns/1ps
`default_nettype none
module tcr_serial_port (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire logic               cfg_sck,
  input  wire logic               cfg_sel_n,
  input  wire logic               cfg_mosi,
  input  wire logic [7:0]         rd_data,
  output tcr_pkg::tcr_port_req_t  req,
  output logic                    miso,
  output logic                    miso_oe
);
  import tcr_pkg::*;

  tcr_port_state_t q, d;
  logic            sck_rise;
  logic            sck_fall;

  assign sck_rise = q.sck_sync[1] & ~q.sck_prev;
  assign sck_fall = ~q.sck_sync[1] & q.sck_prev;

  always_comb begin
    d              = q;
    d.sck_sync     = {q.sck_sync[0], cfg_sck};
    d.sel_n_sync   = {q.sel_n_sync[0], cfg_sel_n};
    d.mosi_sync    = {q.mosi_sync[0], cfg_mosi};
    d.sck_prev     = q.sck_sync[1];
    d.req.wr_valid = 1'b0;
    if (q.sel_n_sync[1]) begin
      d.bit_cnt  = '0;
      d.hdr_read = 1'b0;
      d.miso     = 1'b0;
      d.miso_oe  = 1'b0;
    end else if (sck_rise && q.bit_cnt != FRAME_BITS) begin
      d.shift_in = {q.shift_in[6:0], q.mosi_sync[1]};
      d.bit_cnt  = q.bit_cnt + 5'h01;
      if (q.bit_cnt == HDR_LAST) begin
        d.hdr_read = d.shift_in[HDR_RW_BIT];
        d.req.addr = d.shift_in[HDR_ADDR_LSB +: ADDR_W];
      end
      if (q.bit_cnt == FRAME_LAST && !q.hdr_read) begin
        d.req.wr_valid = 1'b1;
        d.req.wr_data  = d.shift_in;
      end
    end else if (sck_fall && q.hdr_read && q.bit_cnt >= HDR_BITS && q.bit_cnt < FRAME_BITS) begin
      if (q.bit_cnt == HDR_BITS) begin
        d.miso      = rd_data[7];
        d.shift_out = {rd_data[6:0], 1'b0};
        d.miso_oe   = 1'b1;
      end else begin
        d.miso      = q.shift_out[7];
        d.shift_out = {q.shift_out[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q <= '0;
      q.sck_sync   <= 2'h0;
      q.sel_n_sync <= 2'h3;
      q.sck_prev   <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign req     = q.req;
  assign miso    = q.miso;
  assign miso_oe = q.miso_oe;
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the main configuration register bank.
// Assumes: Serial frames of start, read flag, address, stop, then one data byte.
// Notes: A bench copy of the six bytes predicts every read and every update.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tcr_pkg::*;
  logic             clk_sys;
  logic             sys_rst;
  logic             cfg_sck;
  logic             cfg_sel_n;
  logic             cfg_mosi;
  logic             cfg_miso;
  logic             cfg_miso_oe;
  tcr_main_params_t main_params;
  tcr_group_t       access_group;
  integer           seed = 32'h0cdb;
  int               fail_count = 0;
  int               comparisons = 0;
  logic [7:0]       m [0:5];
  logic [7:0]       q;
  logic [4:0]       ra;
  logic [7:0]       rv;

  tcr_main_config_regs dut (
    .clk_sys      (clk_sys),
    .sys_rst      (sys_rst),
    .cfg_sck      (cfg_sck),
    .cfg_sel_n    (cfg_sel_n),
    .cfg_mosi     (cfg_mosi),
    .cfg_miso     (cfg_miso),
    .cfg_miso_oe  (cfg_miso_oe),
    .main_params  (main_params),
    .access_group (access_group)
  );

  always #12.5 clk_sys = ~clk_sys;

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] expv);
    comparisons++;
    if (seen !== expv) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Counts: comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Predicts the group that an address decodes to.
  function automatic tcr_group_t grp(input logic [4:0] a);
    if (a <= 5'h0b) return GRP_MAIN;
    if (a <= 5'h0f) return GRP_IRQ;
    if (a <= 5'h15) return GRP_RX;
    if (a <= 5'h19) return GRP_SYNC;
    if (a == 5'h1a) return GRP_TX;
    if (a == 5'h1b) return GRP_OSC;
    if (a <= 5'h1e) return GRP_PKT;
    return GRP_NONE;
  endfunction

  function automatic logic [47:0] exp_params();
    return {m[0], m[1], m[2], m[3], m[4], m[5]};
  endfunction

  // Sends one frame; a short count of bits aborts it before the data byte ends.
  task automatic frame(input logic rd, input logic [4:0] a, input logic [7:0] d,
                       input int nbits);
    logic [15:0] f;
    f = {1'b0, rd, a, 1'b0, d};
    cfg_sel_n <= 1'b0;
    wait_clk(4);
    for (int i = 0; i < nbits; i++) begin
      cfg_sck  <= 1'b0;
      cfg_mosi <= f[15-i];
      wait_clk(6);
      if (rd && i >= 8) begin
        q[15-i] = cfg_miso;
        check("miso_oe", 48'(cfg_miso_oe), 48'h0000_0000_0001);
      end
      cfg_sck <= 1'b1;
      wait_clk(6);
    end
    cfg_sck <= 1'b0;
    wait_clk(4);
    cfg_sel_n <= 1'b1;
    wait_clk(8);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    frame(1'b0, a, d, 16);
    if (a < 5'h06) begin
      m[a] = (a == 5'h05) ? (d & 8'he0) : d;
    end
    check("main_params", main_params, exp_params());
    check("access_group", 48'(access_group), 48'(grp(a)));
  endtask

  task automatic rd(input logic [4:0] a);
    frame(1'b1, a, 8'h00, 16);
    check("read_data", 48'(q), 48'((a < 5'h06) ? m[a] : 8'h00));
  endtask

  initial begin
    clk_sys   = 1'b0;
    sys_rst   = 1'b1;
    cfg_sck   = 1'b0;
    cfg_sel_n = 1'b1;
    cfg_mosi  = 1'b0;
    m = '{8'h30, 8'h24, 8'h03, 8'h07, 8'h0f, 8'hc0};
    wait_clk(4);
    sys_rst <= 1'b0;
    wait_clk(4);
    check("reset_params", main_params, 48'h3024_0307_0fc0);
    check("reset_group", 48'(access_group), 48'(GRP_NONE));
    check("reset_oe", 48'(cfg_miso_oe), 48'h0000_0000_0000);
    for (int a = 0; a < 6; a++) begin
      rd(5'(a));
    end
    // Every mode, band, sub-band and two-bit code, reserved bits of byte 5 set.
    for (int k = 0; k < 8; k++) begin
      wr(5'h00, {3'(k), 3'(k), 2'(k)});
      wr(5'h01, {4{2'(k)}});
      wr(5'h05, {2'(k), 1'(k), 5'h1f});
      rd(5'h05);
      rd(5'h01);
    end
    wr(5'h04, 8'h0f);
    wr(5'h04, 8'hff);
    wr(5'h03, 8'h00);
    wr(5'h02, 8'hff);
    rd(5'h02);
    frame(1'b0, 5'h02, 8'h55, 10);
    check("abort_params", main_params, exp_params());
    check("abort_group", 48'(access_group), 48'(GRP_MAIN));
    for (int a = 0; a < 32; a++) begin
      wr(5'(a), 8'h5a);
      rd(5'(a));
    end
    for (int n = 0; n < 24; n++) begin
      ra = 5'($random(seed));
      rv = 8'($random(seed));
      if (ra == 5'h04 && rv < 8'h0f) begin
        rv = rv | 8'h10;
      end
      wr(ra, rv);
      rd(ra);
    end
    // A second reset in mid-run restores every reset value.
    sys_rst <= 1'b1;
    wait_clk(4);
    sys_rst <= 1'b0;
    m = '{8'h30, 8'h24, 8'h03, 8'h07, 8'h0f, 8'hc0};
    wait_clk(4);
    check("rerun_params", main_params, 48'h3024_0307_0fc0);
    check("rerun_group", 48'(access_group), 48'(GRP_NONE));
    check("rerun_oe", 48'(cfg_miso_oe), 48'h0000_0000_0000);
    rd(5'h00);
    rd(5'h05);
    report_and_stop();
  end

  initial begin
    #2_500_000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
